// *** act_pkg.sv ***
`default_nettype none
package act_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] ACT_OFS_CAL_CFG0     = 12'h050;
	localparam logic [11:0] ACT_OFS_CAL_BACK     = 12'h057;
	localparam logic [11:0] ACT_OFS_PAT_OVR      = 12'h058;
	localparam logic [11:0] ACT_OFS_VECTOR_SCAN  = 12'h05a;
	localparam logic [11:0] ACT_OFS_STATE_FLAGS  = 12'h05b;
	localparam logic [11:0] ACT_OFS_TIMING_CAL   = 12'h066;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ACT_RST_CAL_CFG0     = 8'h06;
	localparam logic [7:0]  ACT_RST_CAL_BACK     = 8'h10;
	localparam logic [7:0]  ACT_RST_PAT_OVR      = 8'h00;
	localparam logic [7:0]  ACT_RST_TIMING_CAL   = 8'h02;
	localparam logic [7:0]  ACT_RST_VECTOR_SCAN  = 8'h00;
	localparam logic [7:0]  ACT_STAT_RSVD        = 8'h08;
	localparam logic [7:0]  ACT_ZERO_BYTE        = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ACT_BIT_SCAN_EN        = 4;
	localparam int ACT_BIT_FG_TRIGGER     = 3;
	localparam int ACT_BIT_BG_RUN         = 1;
	localparam int ACT_BIT_BG_MODE        = 0;
	localparam int ACT_BIT_TEST_PATTERN   = 2;
	localparam int ACT_BIT_OVERRANGE_EN   = 1;
	localparam int ACT_BIT_STOPPED        = 1;
	localparam int ACT_BIT_FIRST_DONE     = 0;
	localparam int ACT_BIT_TIMING_AUTO    = 0;

	// ----------------------------------------------------------------
	// Bundles
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} act_cfg_req_t;

	typedef struct packed
	{
		logic        fg_start;
		logic        timing_opt_start;
		logic        bg_mode;
		logic        bg_run;
	} act_cal_ctrl_t;

endpackage
`default_nettype wire

// *** act_sample_path.sv ***
`timescale 1ns/1ps
`default_nettype none
module act_sample_path
#(
	parameter int SAMPLE_W = 12
)
(
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                pattern_en,
	input  wire logic                overrange_en,
	input  wire logic [SAMPLE_W-1:0] sample_in,
	input  wire logic                overrange_in,
	output logic      [SAMPLE_W-1:0] sample_out,
	output logic                     overrange_out
);
	import act_pkg::*;

	logic [SAMPLE_W-1:0] ramp_r;

	// ----------------------------------------------------------------
	// Ramp pattern and output select
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ramp_r <= '0;
		else if (pattern_en)
			ramp_r <= ramp_r + SAMPLE_W'(1);
		else
			ramp_r <= '0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sample_out <= '0;
		else if (pattern_en)
			sample_out <= ramp_r;
		else
			sample_out <= sample_in;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			overrange_out <= 1'b0;
		else
			overrange_out <= overrange_en & overrange_in;
	end

endmodule
`default_nettype wire

// *** act_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module act_regs
#(
	parameter int SAMPLE_W = 12,
	parameter int SCAN_AW  = 8
)
(
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire act_pkg::act_cfg_req_t  cfg_req,
	output logic      [7:0]             cfg_rdata,
	output logic                        cfg_rvalid,
	input  wire logic                   cal_active,
	input  wire logic                   cal_seq_done,
	output act_pkg::act_cal_ctrl_t      cal_ctrl,
	output logic      [SCAN_AW-1:0]     scan_index,
	output logic                        scan_wr,
	output logic      [7:0]             scan_wdata,
	input  wire logic [7:0]             scan_rdata,
	input  wire logic [SAMPLE_W-1:0]    sample_in,
	input  wire logic                   overrange_in,
	output logic      [SAMPLE_W-1:0]    sample_out,
	output logic                        overrange_out
);
	import act_pkg::*;

	logic [7:0]         cfg0_r;
	logic [7:0]         back_r;
	logic [7:0]         pat_r;
	logic [7:0]         tcal_r;
	logic               first_done_r;
	logic [SCAN_AW-1:0] scan_idx_r;
	logic               fg_start_r;
	logic               topt_start_r;
	logic               scan_en;
	logic               vec_acc;
	logic [7:0]         stat_val;
	logic [7:0]         rd_nxt;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	assign scan_en  = cfg0_r[ACT_BIT_SCAN_EN];
	assign vec_acc  = scan_en & (cfg_req.wr | cfg_req.rd)
		& (cfg_req.addr == ACT_OFS_VECTOR_SCAN);

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg0_r <= ACT_RST_CAL_CFG0;
			back_r <= ACT_RST_CAL_BACK;
			pat_r  <= ACT_RST_PAT_OVR;
			tcal_r <= ACT_RST_TIMING_CAL;
		end
		else
		begin
			// Trigger bit holds one cycle only
			cfg0_r[ACT_BIT_FG_TRIGGER] <= 1'b0;
			if (cfg_req.wr)
			begin
				if (cfg_req.addr == ACT_OFS_CAL_CFG0)
					cfg0_r <= cfg_req.wdata;
				else if (cfg_req.addr == ACT_OFS_CAL_BACK)
					back_r <= cfg_req.wdata;
				else if (cfg_req.addr == ACT_OFS_PAT_OVR)
					pat_r <= cfg_req.wdata;
				else if (cfg_req.addr == ACT_OFS_TIMING_CAL)
					tcal_r <= cfg_req.wdata;
				// Status offset falls through: no effect
			end
		end
	end

	// ----------------------------------------------------------------
	// Calibration triggers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fg_start_r   <= 1'b0;
			topt_start_r <= 1'b0;
		end
		else
		begin
			fg_start_r <= cfg_req.wr & (cfg_req.addr == ACT_OFS_CAL_CFG0)
				& cfg_req.wdata[ACT_BIT_FG_TRIGGER];
			topt_start_r <= cfg_req.wr & (cfg_req.addr == ACT_OFS_CAL_CFG0)
				& cfg_req.wdata[ACT_BIT_FG_TRIGGER]
				& tcal_r[ACT_BIT_TIMING_AUTO];
		end
	end

	assign cal_ctrl.fg_start         = fg_start_r;
	assign cal_ctrl.timing_opt_start = topt_start_r;
	assign cal_ctrl.bg_mode          = back_r[ACT_BIT_BG_MODE];
	assign cal_ctrl.bg_run           = back_r[ACT_BIT_BG_RUN];

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			first_done_r <= 1'b0;
		else if (cal_seq_done)
			first_done_r <= 1'b1;
	end

	// Engine holds cal_active to the end of a sequence after run clears
	always_comb
	begin
		stat_val = ACT_STAT_RSVD;
		stat_val[ACT_BIT_STOPPED]    = ~cal_active;
		stat_val[ACT_BIT_FIRST_DONE] = first_done_r;
	end

	// ----------------------------------------------------------------
	// Vector scan port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			scan_idx_r <= '0;
		else if (!scan_en)
			scan_idx_r <= '0;
		else if (vec_acc)
			scan_idx_r <= scan_idx_r + SCAN_AW'(1);
	end

	assign scan_index = scan_idx_r;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scan_wr    <= 1'b0;
			scan_wdata <= ACT_RST_VECTOR_SCAN;
		end
		else
		begin
			scan_wr <= vec_acc & cfg_req.wr;
			if (vec_acc & cfg_req.wr)
				scan_wdata <= cfg_req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_nxt = ACT_ZERO_BYTE;
		if (cfg_req.addr == ACT_OFS_CAL_CFG0)
			rd_nxt = cfg0_r;
		else if (cfg_req.addr == ACT_OFS_CAL_BACK)
			rd_nxt = back_r;
		else if (cfg_req.addr == ACT_OFS_PAT_OVR)
			rd_nxt = pat_r;
		else if (cfg_req.addr == ACT_OFS_VECTOR_SCAN)
			rd_nxt = scan_en ? scan_rdata : ACT_RST_VECTOR_SCAN;
		else if (cfg_req.addr == ACT_OFS_STATE_FLAGS)
			rd_nxt = stat_val;
		else if (cfg_req.addr == ACT_OFS_TIMING_CAL)
			rd_nxt = tcal_r;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_rdata  <= ACT_ZERO_BYTE;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_req.rd;
			if (cfg_req.rd)
				cfg_rdata <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Sample output path
	// ----------------------------------------------------------------
	act_sample_path
	#(
		.SAMPLE_W (SAMPLE_W)
	)
	u_sample
	(
		.clk           (clk),
		.rst_b         (rst_b),
		.pattern_en    (pat_r[ACT_BIT_TEST_PATTERN]),
		.overrange_en  (pat_r[ACT_BIT_OVERRANGE_EN]),
		.sample_in     (sample_in),
		.overrange_in  (overrange_in),
		.sample_out    (sample_out),
		.overrange_out (overrange_out)
	);

endmodule
`default_nettype wire

// *** act_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module act_regs_asserts
import act_pkg::*;
#(
	parameter int SAMPLE_W = 12,
	parameter int SCAN_AW  = 8
)
(
	input wire logic                   clk,
	input wire logic                   rst_b,
	input wire act_pkg::act_cfg_req_t  cfg_req,
	input wire logic [7:0]             cfg_rdata,
	input wire logic                   cfg_rvalid,
	input wire logic                   cal_active,
	input wire logic                   cal_seq_done,
	input wire act_pkg::act_cal_ctrl_t cal_ctrl,
	input wire logic [SCAN_AW-1:0]     scan_index,
	input wire logic                   scan_wr,
	input wire logic [7:0]             scan_wdata,
	input wire logic [7:0]             scan_rdata,
	input wire logic [SAMPLE_W-1:0]    sample_in,
	input wire logic                   overrange_in,
	input wire logic [SAMPLE_W-1:0]    sample_out,
	input wire logic                   overrange_out
);
	// --------
	// Checks
	// --------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_vec_read_data: assert property (
		(cfg_req.rd && cfg_req.addr == ACT_OFS_VECTOR_SCAN)
		##1 scan_index != 0 |-> cfg_rdata == $past(scan_rdata))
		else $error("vector data wrong");
	a_scan_wr_cause: assert property (scan_wr |->
		$past(cfg_req.wr && cfg_req.addr == ACT_OFS_VECTOR_SCAN)
		&& scan_wdata == $past(cfg_req.wdata)) else $error("stray scan write");
	a_scan_index_step: assert property ($changed(scan_index) |->
		scan_index - $past(scan_index) == 1 || scan_index == 0)
		else $error("scan index jumped");
	a_stat_stopped: assert property (
		cfg_req.rd && cfg_req.addr == ACT_OFS_STATE_FLAGS |=> cfg_rdata[7:2]
		== 6'h02 && cfg_rdata[1] == !$past(cal_active)) else $error("bad status");
	a_fg_start_pulse: assert property (cfg_req.wr && cfg_req.wdata[3] &&
		cfg_req.addr == ACT_OFS_CAL_CFG0 |=> cal_ctrl.fg_start)
		else $error("trigger lost");
	a_fg_start_cause: assert property (cal_ctrl.fg_start |->
		$past(cfg_req.wr && cfg_req.wdata[3] && cfg_req.addr == ACT_OFS_CAL_CFG0))
		else $error("trigger without write");
	a_timing_with_fg: assert property
		(cal_ctrl.timing_opt_start |-> cal_ctrl.fg_start)
		else $error("timing start without trigger");
	a_overrange_cause: assert property
		(overrange_out |-> $past(overrange_in)) else $error("over-range stray");
	a_bg_run_write: assert property (cfg_req.wr &&
		cfg_req.addr == ACT_OFS_CAL_BACK |=> cal_ctrl.bg_run ==
		$past(cfg_req.wdata[1])) else $error("run control not stored");
endmodule
bind act_regs act_regs_asserts #(.SAMPLE_W(SAMPLE_W), .SCAN_AW(SCAN_AW)) u_chk
(
	.clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
	.cfg_rvalid(cfg_rvalid), .cal_active(cal_active),
	.cal_seq_done(cal_seq_done), .cal_ctrl(cal_ctrl), .scan_index(scan_index),
	.scan_wr(scan_wr), .scan_wdata(scan_wdata), .scan_rdata(scan_rdata),
	.sample_in(sample_in), .overrange_in(overrange_in),
	.sample_out(sample_out), .overrange_out(overrange_out)
);
`default_nettype wire

// *** act_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module act_regs_test;
import act_pkg::*;
	logic           clk;
	logic           rst_b;
	act_cfg_req_t   req;
	logic [7:0]     rdata;
	logic           rvalid;
	logic           act;
	logic           sdone;
	act_cal_ctrl_t  ctrl;
	logic [7:0]     sidx;
	logic           swr;
	logic [7:0]     swd;
	logic [7:0]     srd;
	logic [11:0]    sin;
	logic           oin;
	logic [11:0]    sout;
	logic           oout;
	logic [7:0]     v;
	int             k;
	int             mismatches;
	int             compares;
	logic [11:0]    ofs [6] = '{12'h050, 12'h057, 12'h058, 12'h066, 12'h05a,
		12'h0ff};
	logic [7:0]     rv [6] = '{8'h06, 8'h10, 8'h00, 8'h02, 8'h00, 8'h00};

	act_regs #(.SAMPLE_W(12), .SCAN_AW(8)) dut
	(
		.clk(clk), .rst_b(rst_b), .cfg_req(req), .cfg_rdata(rdata),
		.cfg_rvalid(rvalid), .cal_active(act), .cal_seq_done(sdone),
		.cal_ctrl(ctrl), .scan_index(sidx), .scan_wr(swr), .scan_wdata(swd),
		.scan_rdata(srd), .sample_in(sin), .overrange_in(oin),
		.sample_out(sout), .overrange_out(oout)
	);

	always #2.5 clk = ~clk;

	// ------------
	// Bench tasks
	// ------------
	function automatic logic [7:0] stat_exp(input logic a, input logic d);
		return ACT_STAT_RSVD | {6'h00, !a, d};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#1;
		req = '0;
	endtask

	// Reads status until the stopped flag shows, bounded
	task automatic poll_stopped;
		int n;
		n = 0;
		do
		begin
			acc(0, ACT_OFS_STATE_FLAGS, 8'h00);
			n++;
		end
		while (!rdata[ACT_BIT_STOPPED] && n < 8);
		chk(rdata[ACT_BIT_STOPPED], 1'b1);
	endtask

	task end_of_test;
		$display("Counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#20000;
		mismatches++;
		end_of_test;
	end

	initial
	begin
		{clk, rst_b, act, sdone, srd, sin, oin} = '0;
		req = '0;
		void'($urandom(32'h91b9));
		repeat (12) @(posedge clk);
		#1;
		rst_b = 1;
		foreach (ofs[i])
		begin
			acc(0, ofs[i], 8'h00);
			chk(rdata, rv[i]);
		end
		acc(1, 12'h05b, 8'hff);
		act = 1;
		acc(0, 12'h05b, 8'h00);
		chk(rdata, stat_exp(1, 0));
		chk(rvalid, 1);
		sdone = 1;
		@(posedge clk);
		#1;
		{sdone, act} = 2'b00;
		acc(0, 12'h05b, 8'h00);
		chk(rdata, stat_exp(0, 1));
		$display("status test done");
		poll_stopped;
		acc(1, 12'h066, 8'h01);
		chk(ctrl.timing_opt_start, 0);
		acc(1, 12'h050, 8'h08);
		chk({ctrl.fg_start, ctrl.timing_opt_start}, 2'b11);
		acc(0, 12'h050, 8'h00);
		chk({rdata, ctrl.fg_start}, {8'h00, 1'b0});
		acc(1, 12'h066, 8'h00);
		acc(1, 12'h050, 8'h08);
		chk({ctrl.fg_start, ctrl.timing_opt_start}, 2'b10);
		act = 1;
		acc(1, 12'h057, 8'h13);
		chk({ctrl.bg_run, ctrl.bg_mode}, 2'b11);
		acc(0, 12'h05b, 8'h00);
		chk(rdata, stat_exp(1, 1));
		acc(1, 12'h057, 8'h11);
		chk({ctrl.bg_run, ctrl.bg_mode}, 2'b01);
		acc(0, 12'h05b, 8'h00);
		chk(rdata, stat_exp(1, 1));
		act = 0;
		poll_stopped;
		$display("calibration control test done");
		acc(1, 12'h058, 8'h02);
		oin = 1;
		repeat (4)
		begin
			sin = 12'($urandom);
			@(posedge clk);
			#1;
			chk({sout, oout}, {sin, 1'b1});
		end
		acc(1, 12'h058, 8'h04);
		for (k = 0; k < 3; k++)
		begin
			sin = 12'($urandom);
			@(posedge clk);
			#1;
			chk({sout, oout}, {12'(k), 1'b0});
		end
		$display("sample path test done");
		acc(1, 12'h050, 8'h10);
		chk(sidx, 0);
		for (k = 1; k < 5; k++)
		begin
			srd = 8'($urandom);
			acc(0, 12'h05a, 8'h00);
			chk({rdata, sidx}, {srd, 8'(k)});
		end
		v = 8'($urandom);
		acc(1, 12'h05a, v);
		chk({swr, swd, sidx}, {1'b1, v, 8'h05});
		acc(1, 12'h050, 8'h00);
		// Index rewinds one cycle after the scan bit clears
		@(posedge clk);
		#1;
		chk(sidx, 0);
		acc(0, 12'h05a, 8'h00);
		chk(rdata, 0);
		$display("scan test done");
		end_of_test;
	end
endmodule
`default_nettype wire
